// ### src/itp_pkg.sv
package itp_pkg;

  // Register offsets and widths of the APB decode and the priority field
  localparam logic [15:0] ITP_TOP_PEND_OFFSET = 16'he268;
  localparam logic [15:0] ITP_STATUS_OFFSET   = 16'he270;
  localparam logic [15:0] ITP_MASK_OFFSET     = 16'he274;
  localparam int          ITP_ADDR_W          = 16;
  localparam int          ITP_DATA_W          = 32;
  localparam int          ITP_PRIO_W          = 4;

  // Source bit positions within the register
  localparam int ITP_WAN_TX_DONE_BIT     = 30;
  localparam int ITP_WAN_RX_BIT          = 29;
  localparam int ITP_WAN_TX_BUF_BIT      = 28;
  localparam int ITP_WAN_RX_BUF_BIT      = 27;
  localparam int ITP_WAN_TX_STOP_BIT     = 26;
  localparam int ITP_WAN_RX_STOP_BIT     = 25;
  localparam int ITP_BUS_ERROR_BIT       = 24;
  localparam int ITP_LAN_WAKEUP_BIT      = 19;
  localparam int ITP_WAN_WAKEUP_BIT      = 18;
  localparam int ITP_LAN_TX_DONE_BIT     = 17;
  localparam int ITP_LAN_RX_BIT          = 16;
  localparam int ITP_LAN_TX_BUF_BIT      = 15;
  localparam int ITP_LAN_RX_BUF_BIT      = 14;
  localparam int ITP_LAN_TX_STOP_BIT     = 13;
  localparam int ITP_LAN_RX_STOP_BIT     = 12;
  localparam int ITP_USB_DEVICE_BIT      = 10;
  localparam int ITP_USB_FS_HOST_BIT     = 9;
  localparam int ITP_USB_HS_HOST_BIT     = 8;
  localparam int ITP_SD_HOST_BIT         = 7;
  localparam int ITP_SECURITY_BIT        = 6;
  localparam int ITP_MEMORY_CTRL_BIT     = 4;

  // Implemented source positions; everything else reads zero
  localparam logic [31:0] ITP_SOURCE_MASK = 32'h7f0f_f7d0;
  localparam logic [31:0] ITP_RESET_VALUE = 32'h0000_0000;

  // Event bits of the status and mask registers
  localparam int ITP_EV_TOP_CHANGE_BIT = 0;
  localparam int ITP_EV_TOP_SET_BIT    = 1;
  localparam int ITP_EV_W              = 2;
  localparam logic [ITP_EV_W-1:0] ITP_EV_RESET = 2'h0;

  typedef logic [ITP_PRIO_W-1:0] itp_prio_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ITP_ADDR_W-1:0] paddr;
    logic [ITP_DATA_W-1:0] pwdata;
  } itp_apb_req_t;

  typedef struct packed {
    logic                  pready;
    logic [ITP_DATA_W-1:0] prdata;
    logic                  pslverr;
  } itp_apb_rsp_t;

endpackage

// ### src/itp_top_finder.sv
`timescale 1ns/1ps
`default_nettype none

module itp_top_finder
  import itp_pkg::*;
#(
  parameter int N = 32
)(
  input  wire logic [N-1:0]      pending,
  input  wire itp_prio_t [N-1:0] prio,
  output logic [N-1:0]           top
);

  itp_prio_t best;

  always_comb
  begin
    best = '0;
    for (int i = 0; i < N; i++)
    begin
      if (pending[i] && (prio[i] > best))
      begin
        best = prio[i];
      end
    end
    top = '0;
    for (int i = 0; i < N; i++)
    begin
      top[i] = pending[i] && (prio[i] == best);
    end
  end

endmodule

`default_nettype wire

// ### src/itp_top_pending.sv
// Operation
// - The top-priority register is read only and writes to it change nothing.
// - A bit is set only if its source is pending on IRQ and has the highest pending priority.
// - All pending sources that share the top priority are flagged together.
// - WAN transmit done is bit 30 and WAN receive is bit 29.
// - WAN transmit buffer unavailable is bit 28 and WAN receive buffer unavailable is bit 27.
// - WAN transmit stopped is bit 26 and WAN receive stopped is bit 25.
// - System bus error response is bit 24.
// - LAN wake-up is bit 19 and WAN wake-up is bit 18.
// - LAN transmit done is bit 17 and LAN receive is bit 16.
// - LAN transmit buffer unavailable is bit 15 and LAN receive buffer unavailable is bit 14.
// - LAN transmit stopped is bit 13 and LAN receive stopped is bit 12.
// - USB device is bit 10, full-speed host bit 9 and high-speed host bit 8.
// - The SD host controller is bit 7.
// - The security engine is bit 6.
// - The external memory controller is bit 4.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module itp_top_pending
  import itp_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire itp_apb_req_t     apb_req,
  output itp_apb_rsp_t          apb_rsp,
  input  wire logic             wan_tx_done,
  input  wire logic             wan_rx,
  input  wire logic             wan_tx_buf_unavail,
  input  wire logic             wan_rx_buf_unavail,
  input  wire logic             wan_tx_stopped,
  input  wire logic             wan_rx_stopped,
  input  wire logic             bus_error,
  input  wire logic             lan_wakeup,
  input  wire logic             wan_wakeup,
  input  wire logic             lan_tx_done,
  input  wire logic             lan_rx,
  input  wire logic             lan_tx_buf_unavail,
  input  wire logic             lan_rx_buf_unavail,
  input  wire logic             lan_tx_stopped,
  input  wire logic             lan_rx_stopped,
  input  wire logic             usb_device,
  input  wire logic             usb_fullspeed_host,
  input  wire logic             usb_highspeed_host,
  input  wire logic             sd_host,
  input  wire logic             security_engine,
  input  wire logic             memory_ctrl,
  input  wire logic [31:0]      irq_enable,
  input  wire logic [31:0]      irq_route_fast,
  input  wire itp_prio_t [31:0] src_prio,
  output logic                  irq_top_event,
  output logic [31:0]           irq_top_priority_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Source gathering

  logic [31:0] raw_pending;
  logic [31:0] src_enabled;
  logic [31:0] src_normal;
  logic [31:0] irq_pending;
  logic [31:0] next_top;
  logic [31:0] next_top_masked;

  always_comb
  begin
    raw_pending = '0;
    // WAN MAC
    raw_pending[ITP_WAN_TX_DONE_BIT] = wan_tx_done;
    raw_pending[ITP_WAN_RX_BIT]      = wan_rx;
    raw_pending[ITP_WAN_TX_BUF_BIT]  = wan_tx_buf_unavail;
    raw_pending[ITP_WAN_RX_BUF_BIT]  = wan_rx_buf_unavail;
    raw_pending[ITP_WAN_TX_STOP_BIT] = wan_tx_stopped;
    raw_pending[ITP_WAN_RX_STOP_BIT] = wan_rx_stopped;

    // Bus error and wake-up
    raw_pending[ITP_BUS_ERROR_BIT]   = bus_error;
    raw_pending[ITP_LAN_WAKEUP_BIT]  = lan_wakeup;
    raw_pending[ITP_WAN_WAKEUP_BIT]  = wan_wakeup;

    // LAN MAC
    raw_pending[ITP_LAN_TX_DONE_BIT] = lan_tx_done;
    raw_pending[ITP_LAN_RX_BIT]      = lan_rx;
    raw_pending[ITP_LAN_TX_BUF_BIT]  = lan_tx_buf_unavail;
    raw_pending[ITP_LAN_RX_BUF_BIT]  = lan_rx_buf_unavail;
    raw_pending[ITP_LAN_TX_STOP_BIT] = lan_tx_stopped;
    raw_pending[ITP_LAN_RX_STOP_BIT] = lan_rx_stopped;

    // USB, SD, security and memory
    raw_pending[ITP_USB_DEVICE_BIT]  = usb_device;
    raw_pending[ITP_USB_FS_HOST_BIT] = usb_fullspeed_host;
    raw_pending[ITP_USB_HS_HOST_BIT] = usb_highspeed_host;
    raw_pending[ITP_SD_HOST_BIT]     = sd_host;
    raw_pending[ITP_SECURITY_BIT]    = security_engine;
    raw_pending[ITP_MEMORY_CTRL_BIT] = memory_ctrl;
  end

  // Enabled, routed to IRQ, and only implemented positions
  assign src_enabled = raw_pending & irq_enable;
  assign src_normal  = src_enabled & ~irq_route_fast;
  assign irq_pending = src_normal & ITP_SOURCE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Top-priority search

  itp_top_finder #(
    .N (32)
  ) u_finder (
    .pending (irq_pending),
    .prio    (src_prio),
    .top     (next_top)
  );

  // Reserved positions never reach the register
  assign next_top_masked = next_top & ITP_SOURCE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Top-priority register, refreshed every cycle

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_top_priority_pending <= ITP_RESET_VALUE;
    end
    else
    begin
      irq_top_priority_pending <= next_top_masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events: top set changed, top set became non-empty

  logic [ITP_EV_W-1:0] ev_status;
  logic [ITP_EV_W-1:0] ev_mask;
  logic [ITP_EV_W-1:0] ev_hit;
  logic                top_changed;
  logic                top_arrived;

  assign top_changed = next_top_masked != irq_top_priority_pending;
  assign top_arrived = (irq_top_priority_pending == '0) && (next_top_masked != '0);

  always_comb
  begin
    ev_hit = '0;
    ev_hit[ITP_EV_TOP_CHANGE_BIT] = top_changed;
    ev_hit[ITP_EV_TOP_SET_BIT]    = top_arrived;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  logic wr_access;
  logic rd_access;

  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_access = apb_req.psel && !apb_req.pwrite;

  function automatic logic hit(input logic [ITP_ADDR_W-1:0] a, input logic [ITP_ADDR_W-1:0] o);
    hit = (a[ITP_ADDR_W-1:2] == o[ITP_ADDR_W-1:2]);
  endfunction

  // Zero extension of an event vector to a bus word
  function automatic logic [ITP_DATA_W-1:0] ev_word(input logic [ITP_EV_W-1:0] v);
    ev_word = {{(ITP_DATA_W-ITP_EV_W){1'b0}}, v};
  endfunction

  // Register selects and strobes, low address bits ignored
  logic sel_top;
  logic sel_status;
  logic sel_mask;
  logic wr_status;
  logic wr_mask;
  logic rd_setup;

  assign sel_top    = hit(apb_req.paddr, ITP_TOP_PEND_OFFSET);
  assign sel_status = hit(apb_req.paddr, ITP_STATUS_OFFSET);
  assign sel_mask   = hit(apb_req.paddr, ITP_MASK_OFFSET);
  assign wr_status  = wr_access && sel_status;
  assign wr_mask    = wr_access && sel_mask;
  assign rd_setup   = rd_access && !apb_req.penable;
  // No write strobe exists for the top-priority word

  ////////////////////////////////////////////////////////////////////////////
  // Event status, write one to clear

  logic [ITP_EV_W-1:0] next_ev_status;
  logic [ITP_EV_W-1:0] next_ev_mask;
  logic                next_irq_top_event;

  // Set wins over write-one-to-clear
  always_comb
  begin
    next_ev_status = ev_status | ev_hit;
    if (wr_status)
    begin
      next_ev_status = (ev_status & ~apb_req.pwdata[ITP_EV_W-1:0]) | ev_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_status <= ITP_EV_RESET;
    end
    else
    begin
      ev_status <= next_ev_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event mask

  always_comb
  begin
    next_ev_mask = ev_mask;
    if (wr_mask)
    begin
      next_ev_mask = apb_req.pwdata[ITP_EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_mask <= ITP_EV_RESET;
    end
    else
    begin
      ev_mask <= next_ev_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level interrupt from registered status and mask

  assign next_irq_top_event = |(ev_status & ev_mask);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_top_event <= 1'b0;
    end
    else
    begin
      irq_top_event <= next_irq_top_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response: bus phase, ready and read data

  // Bus phase as seen by this slave
  typedef enum logic {PH_IDLE, PH_ACCESS} itp_bus_phase_t;

  itp_bus_phase_t        bus_phase;
  itp_bus_phase_t        next_bus_phase;
  logic [ITP_DATA_W-1:0] next_prdata;

  // Access phase follows every setup cycle
  always_comb
  begin
    next_bus_phase = PH_IDLE;
    unique case (bus_phase)
      PH_IDLE:
      begin
        if (apb_req.psel && !apb_req.penable)
        begin
          next_bus_phase = PH_ACCESS;
        end
      end
      PH_ACCESS:
      begin
        // Zero wait states, so the access ends here
        next_bus_phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_phase <= PH_IDLE;
    end
    else
    begin
      bus_phase <= next_bus_phase;
    end
  end

  // Read data captured in setup; cleared while the bus idles
  always_comb
  begin
    next_prdata = apb_rsp.prdata;
    if (rd_setup)
    begin
      if (sel_top)
      begin
        next_prdata = irq_top_priority_pending;
      end
      else if (sel_status)
      begin
        next_prdata = ev_word(ev_status);
      end
      else if (sel_mask)
      begin
        next_prdata = ev_word(ev_mask);
      end
      else
      begin
        next_prdata = '0;
      end
    end
    else if (!apb_req.psel)
    begin
      next_prdata = '0;
    end
  end

  // Ready stands for the single access cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      apb_rsp <= '0;
    end
    else
    begin
      apb_rsp.pready  <= next_bus_phase == PH_ACCESS;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.prdata  <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// ### bench/itp_top_pending_chk.sv
`timescale 1ns/1ps
`default_nettype none

module itp_top_pending_chk
  import itp_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire itp_apb_req_t apb_req,
  input wire itp_apb_rsp_t apb_rsp,
  input wire logic [31:0]  irq_enable,
  input wire logic [31:0]  irq_route_fast,
  input wire logic [31:0]  irq_top_priority_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  a_reserved_zero: assert property ((irq_top_priority_pending & ~ITP_SOURCE_MASK) == '0)
    else $error("reserved bit set");
  a_fast_excluded: assert property ((irq_top_priority_pending & $past(irq_route_fast)) == '0)
    else $error("fast source flagged");
  a_disabled_off: assert property ((irq_top_priority_pending & ~$past(irq_enable)) == '0)
    else $error("disabled source flagged");
  a_read_capture: assert property (s_setup ##0 (!apb_req.pwrite && apb_req.paddr == ITP_TOP_PEND_OFFSET)
    |=> apb_rsp.prdata == $past(irq_top_priority_pending))
    else $error("read data wrong");
  a_ready_follows: assert property (s_setup |=> apb_rsp.pready)
    else $error("pready late");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held");
  a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
    else $error("pready without setup");
  a_no_error: assert property (!apb_rsp.pslverr)
    else $error("pslverr raised");
endmodule

bind itp_top_pending itp_top_pending_chk u_itp_top_pending_chk (.clk_sys, .rst_b, .apb_req,
  .apb_rsp, .irq_enable, .irq_route_fast, .irq_top_priority_pending);

`default_nettype wire

// ### bench/itp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module itp_cpu_model
  import itp_pkg::*;
(
  input  wire logic         clk_sys,
  output var itp_apb_req_t  apb_req,
  input  wire itp_apb_rsp_t apb_rsp
);
  initial apb_req = '0;

  // Waits for pready with no assumed latency
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    apb_req <= '0;
  endtask
endmodule

`default_nettype wire

// ### bench/itp_top_pending_bench.sv
`timescale 1ns/1ps
`default_nettype none

module itp_top_pending_bench import itp_pkg::*;;
  logic             clk_sys = 1'b0;
  logic             rst_b = 1'b0;
  itp_apb_req_t     apb_req;
  itp_apb_rsp_t     apb_rsp;
  logic [31:0]      src = '0;
  logic [31:0]      en = '0;
  logic [31:0]      rt = '0;
  itp_prio_t [31:0] pr = '0;
  itp_prio_t [31:0] pv = '0;
  logic             ev;
  logic [31:0]      top;
  logic [31:0]      rd;
  int               fails = 0;
  int               cmp_count = 0;

  itp_cpu_model u_itp_cpu_model (.clk_sys, .apb_req, .apb_rsp);
  itp_top_pending u_itp_top_pending (.clk_sys, .rst_b, .apb_req, .apb_rsp,
    .wan_tx_done(src[30]), .wan_rx(src[29]), .wan_tx_buf_unavail(src[28]),
    .wan_rx_buf_unavail(src[27]), .wan_tx_stopped(src[26]), .wan_rx_stopped(src[25]),
    .bus_error(src[24]), .lan_wakeup(src[19]), .wan_wakeup(src[18]), .lan_tx_done(src[17]),
    .lan_rx(src[16]), .lan_tx_buf_unavail(src[15]), .lan_rx_buf_unavail(src[14]),
    .lan_tx_stopped(src[13]), .lan_rx_stopped(src[12]), .usb_device(src[10]),
    .usb_fullspeed_host(src[9]), .usb_highspeed_host(src[8]), .sd_host(src[7]),
    .security_engine(src[6]), .memory_ctrl(src[4]), .irq_enable(en), .irq_route_fast(rt),
    .src_prio(pr), .irq_top_event(ev), .irq_top_priority_pending(top));

  initial forever #12.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ap(input logic w, input logic [15:0] a, input logic [31:0] d);
    u_itp_cpu_model.xfer(w, a, d, rd);
  endtask

  task automatic drive(input logic [31:0] s, input logic [31:0] e, input logic [31:0] r);
    @(posedge clk_sys);
    src <= s;
    en <= e;
    rt <= r;
    pr <= pv;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk(top, ITP_RESET_VALUE);
    ap(1'b0, ITP_TOP_PEND_OFFSET, '0);
    chk(rd, ITP_RESET_VALUE);
    for (int i = 0; i < 32; i++)
      pv[i] = 4'h5;
    drive('1, '1, '0);
    chk(top, ITP_SOURCE_MASK);
    for (int b = 0; b < 32; b++)
    begin
      if (ITP_SOURCE_MASK[b])
      begin
        pv[b] = 4'h9;
        drive('1, '1, '0);
        chk(top, 32'h0000_0001 << b);
        pv[b] = 4'h5;
      end
    end
    pv[30] = 4'h9;
    pv[29] = 4'h9;
    drive('1, 32'hbfff_ffff, 32'h2000_0000);
    chk(top, 32'h1f0f_f7d0);
    pv[4] = 4'h0;
    drive(32'h0000_0010, '1, '0);
    chk(top, 32'h0000_0010);
    ap(1'b1, ITP_TOP_PEND_OFFSET, 32'hffff_ffff);
    ap(1'b0, ITP_TOP_PEND_OFFSET, '0);
    chk(rd, 32'h0000_0010);
    ap(1'b0, 16'he300, '0);
    chk(rd, 32'h0000_0000);
    drive('0, '1, '0);
    chk(top, 32'h0000_0000);
    ap(1'b1, ITP_STATUS_OFFSET, 32'h0000_0003);
    drive(32'h0000_0040, '1, '0);
    chk({31'h0, ev}, 32'h0000_0000);
    ap(1'b0, ITP_STATUS_OFFSET, '0);
    chk(rd, 32'h0000_0003);
    ap(1'b1, ITP_MASK_OFFSET, 32'h0000_0002);
    drive(32'h0000_0040, '1, '0);
    chk({31'h0, ev}, 32'h0000_0001);
    ap(1'b1, ITP_STATUS_OFFSET, 32'h0000_0003);
    drive('0, '1, '0);
    chk({31'h0, ev}, 32'h0000_0000);
    print_verdict();
  end
endmodule

`default_nettype wire
